// ===== pkg/ixw_pkg.sv
// Purpose: Shared constants and types for index write-back and tag read
// Assumes: 32-bit instruction and address, four cache selectors
// Notes: Register offsets are byte addresses on the AHB-Lite slave
package ixw_pkg;
  // Instruction fields
  localparam int OP_LSB = 18;
  localparam int OP_MSB = 20;
  localparam int SEL_LSB = 16;
  localparam int SEL_MSB = 17;
  localparam logic [2:0] OP_IDX_WB_INV = 3'h0;
  localparam logic [2:0] OP_IDX_LD_TAG = 3'h1;
  // Cache selectors
  localparam logic [1:0] CSEL_I = 2'h0;
  localparam logic [1:0] CSEL_D = 2'h1;
  localparam logic [1:0] CSEL_T = 2'h2;
  localparam logic [1:0] CSEL_S = 2'h3;
  localparam int NCACHE = 4;
  // Default geometry
  localparam int DEF_SETS = 16;
  localparam int DEF_WAYS = 2;
  localparam int DEF_LINE_WORDS = 4;
  localparam int PAIR_BYTE_LSB = 3;
  localparam int PAIR_BITS = 64;
  // Register map
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TAG_LO = 8'h08;
  localparam logic [7:0] REG_TAG_HI = 8'h0C;
  localparam logic [7:0] REG_DATA_LO = 8'h10;
  localparam logic [7:0] REG_DATA_HI = 8'h14;
  localparam int CFG_WB_BIT = 0;
  localparam int CFG_S_BIT = 1;
  localparam int CFG_T_BIT = 2;
  localparam logic [2:0] CFG_RST = 3'h1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WB_BIT = 1;
  localparam int TL_VALID_BIT = 0;
  localparam int TL_DIRTY_BIT = 1;
  localparam int TL_PERR_BIT = 2;
  localparam int TL_TAG_LSB = 8;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_WB} ixw_fsm_t;
endpackage

// ===== src/ixw_index_wb_tag_read.sv
// Purpose: Executes index write-back-invalidate and index tag read
// Assumes: Requests and write-back answers come from core-clock logic
// Notes: Registers on AHB-Lite, zero wait states, always OKAY
//
// Summary of operation
// (R1) The operation code is taken from instruction bits 20 to 18.
// (R2) A valid dirty line of a write-back cache is written to its tag address.
// (R3) Such a line is invalidated only after its write-back is acknowledged.
// (R4) A valid clean line is invalidated with no memory write.
// (R5) In write-through mode the line is simply invalidated.
// (R6) Write-back-invalidate serves the data cache and any present S or T.
// (R7) Code 001 copies the line tag into the tag holding registers.
// (R8) The same operation loads the line data holding registers.
// (R9) Tag read never raises an error, even on a parity fault.
// (R10) Data read is an aligned 64-bit pair, low byte-index bits ignored.
// (R11) Software initialises caches with index store tag, not this block.
// (R12) Software may walk every set and way to flush the data cache.
// (R13) Set and way come from a fixed split of the effective address.
`timescale 1ns/1ps
module ixw_index_wb_tag_read
  import ixw_pkg::*;
#(
  parameter int SETS = DEF_SETS,
  parameter int WAYS = DEF_WAYS,
  parameter int LINE_WORDS = DEF_LINE_WORDS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic [31:0] req_instr_i,
  input wire logic [31:0] req_addr_i,
  output logic req_ready_o,
  output logic done_o,
  output logic wb_valid_o,
  output logic [31:0] wb_addr_o,
  output logic [LINE_WORDS*32-1:0] wb_data_o,
  input wire logic wb_ack_i,
  input wire logic fill_en_i,
  input wire logic [1:0] fill_cache_i,
  input wire logic [31:0] fill_addr_i,
  input wire logic fill_valid_i,
  input wire logic fill_dirty_i,
  input wire logic fill_perr_i,
  input wire logic [LINE_WORDS*32-1:0] fill_data_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o
);
  localparam int LINE_W = LINE_WORDS * 32;
  localparam int OFF_W = $clog2(LINE_WORDS * 4);
  localparam int SET_W = $clog2(SETS);
  localparam int WAY_W = $clog2(WAYS);
  localparam int PAIR_W = $clog2(LINE_WORDS / 2);
  localparam int TAG_W = 32 - OFF_W - SET_W;

  if (WAYS < 2 || (WAYS & (WAYS - 1)) != 0 || SETS < 2 ||
      (SETS & (SETS - 1)) != 0 || LINE_WORDS < 4 ||
      (LINE_WORDS & (LINE_WORDS - 1)) != 0 || OFF_W + SET_W < TL_TAG_LSB ||
      OFF_W + SET_W + WAY_W > 32) begin : g_bad_geometry
    $error("ixw: unsupported cache geometry");
  end

  typedef struct packed {
    ixw_fsm_t fsm;
    logic [2:0] op;
    logic [1:0] sel;
    logic [SET_W-1:0] set;
    logic [WAY_W-1:0] way;
    logic [PAIR_W-1:0] pair;
    logic [2:0] cfg;
    logic [31:0] tag_lo;
    logic [31:0] tag_hi;
    logic [31:0] data_lo;
    logic [31:0] data_hi;
    logic wb_valid;
    logic [31:0] wb_addr;
    logic [LINE_W-1:0] wb_data;
    logic done;
    logic ready;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] hrdata;
    logic hreadyout;
  } ixw_state_t;

  ixw_state_t q, n;

  // Write-back-invalidate targets only the data cache and present S, T
  function automatic logic wbi_target(input logic [1:0] sel,
                                      input logic [2:0] cfg);
    case (sel)
      CSEL_D: wbi_target = 1'b1;
      CSEL_S: wbi_target = cfg[CFG_S_BIT];
      CSEL_T: wbi_target = cfg[CFG_T_BIT];
      default: wbi_target = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] reg_rd(input logic [7:0] a,
                                         input ixw_state_t s,
                                         input logic [2:0] cfg);
    reg_rd = 32'h0000_0000;
    case (a)
      REG_CFG: reg_rd[2:0] = cfg;
      REG_STATUS: begin
        reg_rd[ST_BUSY_BIT] = (s.fsm != ST_IDLE);
        reg_rd[ST_WB_BIT] = s.wb_valid;
      end
      REG_TAG_LO: reg_rd = s.tag_lo;
      REG_TAG_HI: reg_rd = s.tag_hi;
      REG_DATA_LO: reg_rd = s.data_lo;
      REG_DATA_HI: reg_rd = s.data_hi;
      default: reg_rd = 32'h0000_0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Line stores, one per cache selector
  logic [TAG_W-1:0] c_tag [NCACHE];
  logic [LINE_W-1:0] c_data [NCACHE];
  logic c_valid [NCACHE];
  logic c_dirty [NCACHE];
  logic c_perr [NCACHE];
  logic [TAG_W-1:0] l_tag;
  logic [LINE_W-1:0] l_data;
  logic l_valid, l_dirty, l_perr;
  logic inv_we, fill_we, st_we;
  logic [1:0] w_sel;
  logic [SET_W-1:0] w_set;
  logic [WAY_W-1:0] w_way;
  logic [TAG_W-1:0] w_tag;
  logic w_valid, w_dirty, w_perr;
  logic [LINE_W-1:0] w_data;
  logic [31:0] pair_lo, pair_hi;

  assign l_tag = c_tag[q.sel];
  assign l_data = c_data[q.sel];
  assign l_valid = c_valid[q.sel];
  assign l_dirty = c_dirty[q.sel];
  assign l_perr = c_perr[q.sel];
  // Aligned pair; byte-index bits below 64-bit alignment are dropped
  assign pair_lo = l_data[q.pair*PAIR_BITS +: 32]; // R10
  assign pair_hi = l_data[q.pair*PAIR_BITS+32 +: 32]; // R10

  // Fills are taken only while idle so they never race an invalidate
  assign fill_we = fill_en_i && (q.fsm == ST_IDLE);
  assign st_we = inv_we || fill_we;
  assign w_sel = inv_we ? q.sel : fill_cache_i;
  assign w_set = inv_we ? q.set : fill_addr_i[OFF_W +: SET_W];
  assign w_way = inv_we ? q.way : fill_addr_i[OFF_W+SET_W +: WAY_W];
  assign w_tag = inv_we ? l_tag : fill_addr_i[31 -: TAG_W];
  assign w_valid = inv_we ? 1'b0 : fill_valid_i;
  assign w_dirty = inv_we ? 1'b0 : fill_dirty_i;
  assign w_perr = inv_we ? l_perr : fill_perr_i;
  assign w_data = inv_we ? l_data : fill_data_i;

  for (genvar c = 0; c < NCACHE; c++) begin : g_cache
    ixw_line_store #(
      .SETS(SETS),
      .WAYS(WAYS),
      .TAG_W(TAG_W),
      .LINE_W(LINE_W)
    ) u_store (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .rd_set_i(q.set),
      .rd_way_i(q.way),
      .rd_tag_o(c_tag[c]),
      .rd_valid_o(c_valid[c]),
      .rd_dirty_o(c_dirty[c]),
      .rd_perr_o(c_perr[c]),
      .rd_data_o(c_data[c]),
      .we_i(st_we && (w_sel == 2'(c))),
      .wr_set_i(w_set),
      .wr_way_i(w_way),
      .wr_tag_i(w_tag),
      .wr_valid_i(w_valid),
      .wr_dirty_i(w_dirty),
      .wr_perr_i(w_perr),
      .wr_data_i(w_data)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = q;
    n.done = 1'b0;
    inv_we = 1'b0;
    case (q.fsm)
      ST_IDLE: begin
        if (req_valid_i) begin
          n.op = req_instr_i[OP_MSB:OP_LSB]; // R1
          n.sel = req_instr_i[SEL_MSB:SEL_LSB];
          n.set = req_addr_i[OFF_W +: SET_W]; // R13
          n.way = req_addr_i[OFF_W+SET_W +: WAY_W]; // R13
          n.pair = req_addr_i[PAIR_BYTE_LSB +: PAIR_W]; // R10
          n.fsm = ST_EVAL;
        end
      end
      ST_EVAL: begin
        n.fsm = ST_IDLE;
        n.done = 1'b1;
        case (q.op) // R1
          OP_IDX_WB_INV: begin
            if (wbi_target(q.sel, q.cfg)) begin // R6
              if (q.cfg[CFG_WB_BIT] && l_valid && l_dirty) begin
                n.wb_valid = 1'b1; // R2
                n.wb_addr = {l_tag, q.set, {OFF_W{1'b0}}}; // R2
                n.wb_data = l_data; // R2
                n.fsm = ST_WB;
                n.done = 1'b0;
              end else begin
                // Clean line, or write-through: drop it at once
                inv_we = 1'b1; // R4 R5
              end
            end
          end
          OP_IDX_LD_TAG: begin
            // Parity state is reported, never trapped
            n.tag_lo = 32'h0000_0000; // R9
            n.tag_lo[TL_TAG_LSB +: TAG_W] = l_tag; // R7
            n.tag_lo[TL_VALID_BIT] = l_valid; // R7
            n.tag_lo[TL_DIRTY_BIT] = l_dirty; // R7
            n.tag_lo[TL_PERR_BIT] = l_perr; // R9
            n.tag_hi = 32'h0000_0000; // R7
            n.data_lo = pair_lo; // R8
            n.data_hi = pair_hi; // R8
          end
          default: begin
          end
        endcase
      end
      ST_WB: begin
        if (wb_ack_i) begin
          n.wb_valid = 1'b0;
          inv_we = 1'b1; // R3
          n.done = 1'b1;
          n.fsm = ST_IDLE;
        end
      end
      default: n.fsm = ST_IDLE;
    endcase
    n.ready = (n.fsm == ST_IDLE);
    // AHB-Lite slave, zero wait states; hsize is ignored, words only
    if (q.ph_valid && q.ph_write && q.ph_addr == REG_CFG) begin
      n.cfg = hwdata_i[2:0];
    end
    n.ph_valid = hsel_i && htrans_i[1] && hready_i;
    if (n.ph_valid) begin
      n.ph_write = hwrite_i;
      n.ph_addr = haddr_i[7:0];
      n.hrdata = hwrite_i ? 32'h0000_0000 : reg_rd(haddr_i[7:0], q, n.cfg);
    end
    n.hreadyout = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.cfg <= CFG_RST;
      q.ready <= 1'b1;
      q.hreadyout <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign req_ready_o = q.ready;
  assign done_o = q.done;
  assign wb_valid_o = q.wb_valid;
  assign wb_addr_o = q.wb_addr;
  assign wb_data_o = q.wb_data;
  assign hreadyout_o = q.hreadyout;
  assign hresp_o = HRESP_OKAY;
  assign hrdata_o = q.hrdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic ev_wbi, ev_ld;
  assign ev_wbi = (q.fsm == ST_EVAL) && (q.op == OP_IDX_WB_INV);
  assign ev_ld = (q.fsm == ST_EVAL) && (q.op == OP_IDX_LD_TAG);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_op_dispatch: assert property ( // R1
    (q.fsm == ST_IDLE && req_valid_i &&
     req_instr_i[OP_MSB:OP_LSB] == OP_IDX_LD_TAG) |=> ##1 done_o)
    else $error("tag read did not finish in two cycles");
  a_index_split: assert property ( // R13
    (q.fsm == ST_IDLE && req_valid_i) |=>
    (q.set == $past(req_addr_i[OFF_W +: SET_W]) &&
     q.way == $past(req_addr_i[OFF_W+SET_W +: WAY_W])))
    else $error("set or way not taken from address");
  a_wb_address: assert property ( // R2
    $rose(wb_valid_o) |->
    (wb_addr_o[OFF_W +: SET_W] == q.set &&
     $past(l_valid) && $past(l_dirty) && q.cfg[CFG_WB_BIT]))
    else $error("write-back address or cause wrong");
  a_inval_after_wb: assert property ( // R3
    (wb_valid_o && !wb_ack_i) |-> (!inv_we ##1 wb_valid_o))
    else $error("line dropped before write-back ended");
  a_clean_inval: assert property ( // R4
    (ev_wbi && wbi_target(q.sel, q.cfg) && l_valid && !l_dirty) |->
    inv_we ##1 (!wb_valid_o && done_o))
    else $error("clean line not invalidated silently");
  a_wt_inval: assert property ( // R5
    (ev_wbi && wbi_target(q.sel, q.cfg) && !q.cfg[CFG_WB_BIT]) |->
    inv_we ##1 !wb_valid_o)
    else $error("write-through line not simply invalidated");
  a_absent_skip: assert property ( // R6
    (ev_wbi && !wbi_target(q.sel, q.cfg)) |-> !inv_we ##1 done_o)
    else $error("absent cache touched");
  a_tag_copy: assert property ( // R7
    ev_ld |=> (q.tag_lo[TL_TAG_LSB +: TAG_W] == $past(l_tag) &&
               q.tag_hi == 32'h0000_0000))
    else $error("tag not copied to holding register");
  a_data_pair: assert property ( // R8
    ev_ld |=> (q.data_lo == $past(pair_lo) && q.data_hi == $past(pair_hi)))
    else $error("line data not copied to holding registers");
  a_no_error: assert property ( // R9
    (ev_ld && l_perr) |=> (done_o && req_ready_o && q.tag_lo[TL_PERR_BIT]))
    else $error("faulty line stalled tag read");

  c_wb_done: cover property (wb_valid_o && wb_ack_i);
  c_clean_inval: cover property (ev_wbi && l_valid && !l_dirty);
  c_load_perr: cover property (ev_ld && l_perr);
endmodule

// ===== src/ixw_line_store.sv
// Purpose: Tag, state and data array of one cache
// Assumes: Asynchronous read, one write per cycle
// Notes: Only valid and dirty are reset; tag and data start undefined
`timescale 1ns/1ps
module ixw_line_store #(
  parameter int SETS = 16,
  parameter int WAYS = 2,
  parameter int TAG_W = 24,
  parameter int LINE_W = 128
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [$clog2(SETS)-1:0] rd_set_i,
  input wire logic [$clog2(WAYS)-1:0] rd_way_i,
  output logic [TAG_W-1:0] rd_tag_o,
  output logic rd_valid_o,
  output logic rd_dirty_o,
  output logic rd_perr_o,
  output logic [LINE_W-1:0] rd_data_o,
  input wire logic we_i,
  input wire logic [$clog2(SETS)-1:0] wr_set_i,
  input wire logic [$clog2(WAYS)-1:0] wr_way_i,
  input wire logic [TAG_W-1:0] wr_tag_i,
  input wire logic wr_valid_i,
  input wire logic wr_dirty_i,
  input wire logic wr_perr_i,
  input wire logic [LINE_W-1:0] wr_data_i
);
  localparam int N = SETS * WAYS;
  localparam int IW = $clog2(N);
  typedef struct packed {
    logic [N-1:0] valid;
    logic [N-1:0] dirty;
  } ixw_ls_state_t;
  ixw_ls_state_t q, n;
  logic [TAG_W-1:0] tag_mem [N];
  logic [LINE_W-1:0] data_mem [N];
  logic perr_mem [N];
  logic [IW-1:0] ri, wi;

  assign ri = {rd_set_i, rd_way_i};
  assign wi = {wr_set_i, wr_way_i};
  assign rd_tag_o = tag_mem[ri];
  assign rd_data_o = data_mem[ri];
  assign rd_perr_o = perr_mem[ri];
  assign rd_valid_o = q.valid[ri];
  assign rd_dirty_o = q.dirty[ri];

  always_comb begin
    n = q;
    if (we_i) begin
      n.valid[wi] = wr_valid_i;
      n.dirty[wi] = wr_dirty_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Payload arrays carry no reset, so they map onto plain memory
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      tag_mem[wi] <= wr_tag_i;
      data_mem[wi] <= wr_data_i;
      perr_mem[wi] <= wr_perr_i;
    end
  end
endmodule

// ===== testbench/ixw_wb_mem_model.sv
// Purpose: Backing memory that takes line write-backs from the block
// Assumes: Same core clock; acknowledge is a level held one cycle
// Notes: Delay input lets the bench answer promptly or slowly
`timescale 1ns/1ps
module ixw_wb_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] delay_i,
  input wire logic wb_valid_i,
  input wire logic [31:0] wb_addr_i,
  input wire logic [127:0] wb_data_i,
  output logic wb_ack_o,
  output logic [31:0] last_addr_o,
  output logic [127:0] last_data_o,
  output logic [7:0] n_wb_o
);
  logic [3:0] wait_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Ack drops right after use so a stale ack never meets the next line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wait_ff <= 4'h0;
      n_wb_o <= 8'h00;
      last_addr_o <= 32'h0;
      last_data_o <= '0;
    end else if (wb_valid_i && wb_ack_o) begin
      last_addr_o <= wb_addr_i;
      last_data_o <= wb_data_i;
      n_wb_o <= n_wb_o + 8'h01;
      wb_ack_o <= 1'b0;
      wait_ff <= 4'h0;
    end else if (wb_valid_i) begin
      wait_ff <= wait_ff + 4'h1;
      wb_ack_o <= (wait_ff >= delay_i);
    end
  end
endmodule

// ===== testbench/tb_index_writeback_and_tag_read.sv
// Purpose: Self-checking bench for index write-back and tag read
// Assumes: Lines are preloaded through the fill port
// Notes: Seeded random lines with hand-picked corner cases
`timescale 1ns/1ps
module tb_index_writeback_and_tag_read;
  import ixw_pkg::*;
  logic clk_i, rst_i, req_valid_i, req_ready_o, done_o, wb_valid_o;
  logic wb_ack_i, fill_en_i, fill_valid_i, fill_dirty_i, fill_perr_i;
  logic hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0] req_instr_i, req_addr_i, wb_addr_o, fill_addr_i, haddr_i;
  logic [31:0] hwdata_i, hrdata_o, m_addr;
  logic [127:0] wb_data_o, fill_data_i, m_data;
  logic [1:0] fill_cache_i, htrans_i;
  logic [2:0] hsize_i;
  logic [3:0] delay;
  logic [7:0] n_wb;
  int failures, n_compared;

  ixw_index_wb_tag_read dut (.clk_i(clk_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_instr_i(req_instr_i),
    .req_addr_i(req_addr_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .wb_valid_o(wb_valid_o), .wb_addr_o(wb_addr_o), .wb_data_o(wb_data_o),
    .wb_ack_i(wb_ack_i), .fill_en_i(fill_en_i), .fill_cache_i(fill_cache_i),
    .fill_addr_i(fill_addr_i), .fill_valid_i(fill_valid_i),
    .fill_dirty_i(fill_dirty_i), .fill_perr_i(fill_perr_i),
    .fill_data_i(fill_data_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .hrdata_o(hrdata_o));

  ixw_wb_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .delay_i(delay),
    .wb_valid_i(wb_valid_o), .wb_addr_i(wb_addr_o), .wb_data_i(wb_data_o),
    .wb_ack_o(wb_ack_i), .last_addr_o(m_addr), .last_data_o(m_data),
    .n_wb_o(n_wb));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] pair_of(logic [31:0] a, logic [127:0] d);
    return a[3] ? d[127:64] : d[63:0];
  endfunction

  function automatic logic [31:0] tag_lo_of(logic [31:0] a, logic [2:0] st);
    return {a[31:8], 5'h00, st[0], st[1], st[2]};
  endfunction

  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic hang();
    failures++;
    wrap_up();
  endtask

  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 50);
    if (k >= 50) hang();
  endtask

  task automatic ahb(logic w, logic [7:0] a, logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {24'h000000, a};
    wait_rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    wait_rdy();
    rd = hrdata_o;
  endtask

  task automatic op(logic [2:0] c, logic [1:0] s, logic [31:0] a,
                    output int n);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_instr_i <= {11'h000, c, s, 16'h0000};
    req_addr_i <= a;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 60);
    if (n >= 60) hang();
  endtask

  task automatic fill(logic [1:0] s, logic [31:0] a, logic [2:0] st,
                      logic [127:0] d);
    @(posedge clk_i);
    fill_en_i <= 1'b1;
    fill_cache_i <= s;
    fill_addr_i <= a;
    {fill_valid_i, fill_dirty_i, fill_perr_i} <= st;
    fill_data_i <= d;
    @(posedge clk_i);
    fill_en_i <= 1'b0;
  endtask

  task automatic tag_chk(logic [1:0] s, logic [31:0] a, logic [2:0] st,
                         logic [127:0] d);
    logic [31:0] r;
    int n;
    op(OP_IDX_LD_TAG, s, a, n);
    chk("tag read latency", 2, n);
    ahb(1'b0, REG_TAG_LO, 32'h0, r);
    chk("tag_holding_low", tag_lo_of(a, st), r);
    ahb(1'b0, REG_TAG_HI, 32'h0, r);
    chk("tag_holding_high", 32'h0, r);
    ahb(1'b0, REG_DATA_LO, 32'h0, r);
    chk("line_data_holding_low", pair_of(a, d) & 64'hFFFFFFFF, r);
    ahb(1'b0, REG_DATA_HI, 32'h0, r);
    chk("line_data_holding_high", pair_of(a, d) >> 32, r);
  endtask

  task automatic wbi(logic [1:0] s, logic [31:0] a, logic wb,
                     logic [127:0] d);
    logic [7:0] c0;
    int n;
    c0 = n_wb;
    op(OP_IDX_WB_INV, s, a, n);
    chk("write-back count", {7'h00, wb}, 8'(n_wb - c0));
    if (wb) begin
      chk("write-back address", {a[31:4], 4'h0}, m_addr);
      chk("write-back data", d, m_data);
      chk("done after ack", int'(delay) + 4, n);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    logic [31:0] a, r;
    logic [127:0] d;
    logic [2:0] st;
    logic wb;
    int n;
    rst_i = 1'b1;
    {req_valid_i, fill_en_i, fill_valid_i, fill_dirty_i, fill_perr_i} = '0;
    {hsel_i, hwrite_i, htrans_i, fill_cache_i} = '0;
    {req_instr_i, req_addr_i, fill_addr_i, haddr_i, hwdata_i} = '0;
    fill_data_i = '0;
    hsize_i = 3'h2;
    delay = 4'h0;
    failures = 0;
    n_compared = 0;
    void'($urandom(99));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("ready after reset", 1'b1, req_ready_o);
    ahb(1'b0, REG_CFG, 32'h0, r);
    chk("cfg reset", CFG_RST, r);
    ahb(1'b0, 8'h40, 32'h0, r);
    chk("unmapped read", 32'h0, r);
    ahb(1'b0, REG_STATUS, 32'h0, r);
    chk("status idle", 32'h0, r);
    chk("response", HRESP_OKAY, hresp_o);
    // Lines are loaded by the fill port, as software would store tags
    for (int i = 0; i < 8; i++) begin
      a = $urandom();
      d = {$urandom(), $urandom(), $urandom(), $urandom()};
      st = {1'b1, (i < 2) ? 1'b1 : 1'($urandom()), 1'b0};
      delay <= (i == 1) ? 4'h6 : 4'($urandom_range(0, 3));
      fill(CSEL_D, a, st, d);
      tag_chk(CSEL_D, a, st, d);
      wbi(CSEL_D, a, st[1], d);
      tag_chk(CSEL_D, a, 3'h0, d);
    end
    ahb(1'b1, REG_CFG, 32'h0, r);
    a = $urandom();
    d = {$urandom(), $urandom(), $urandom(), $urandom()};
    fill(CSEL_D, a, 3'h6, d);
    wbi(CSEL_D, a, 1'b0, d);
    tag_chk(CSEL_D, a, 3'h0, d);
    // Every cache, with S and T absent and then present; walks all selectors
    for (int k = 0; k < 2; k++) begin
      ahb(1'b1, REG_CFG, (k == 1) ? 32'h7 : 32'h1, r);
      for (int j = 0; j < NCACHE; j++) begin
        a = $urandom();
        d = {$urandom(), $urandom(), $urandom(), $urandom()};
        wb = (j == 1) || (k == 1 && j != 0);
        fill(2'(j), a, 3'h6, d);
        wbi(2'(j), a, wb, d);
        tag_chk(2'(j), a, wb ? 3'h0 : 3'h6, d);
      end
    end
    ahb(1'b0, REG_CFG, 32'h0, r);
    chk("cfg readback", 32'h7, r);
    a = $urandom() | 32'h8;
    d = {$urandom(), $urandom(), $urandom(), $urandom()};
    fill(CSEL_I, a, 3'h5, d);
    tag_chk(CSEL_I, a, 3'h5, d);
    // Other codes must complete and leave the line alone
    for (int c = 2; c < 8; c++) begin
      op(3'(c), CSEL_I, a, n);
      chk("other op latency", 2, n);
    end
    a[3] = 1'b0;
    tag_chk(CSEL_I, a, 3'h5, d);
    wrap_up();
  end
endmodule
